// File: core/static_memory_bank_controller.v
// Static memory bank controller: bus slave, bank registers, external cycles
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.vh"

module static_memory_bank_controller (
	input wire i_clk_sys,
	input wire i_rst_b,
	input wire i_hsel,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [2:0] i_hsize,
	input wire [31:0] i_hwdata,
	input wire i_hready,
	output wire [31:0] o_hrdata,
	output wire o_hreadyout,
	output wire [1:0] o_hresp,
	output wire [23:0] o_addr,
	input wire [31:0] i_data,
	output wire [31:0] o_data,
	output wire o_data_oe,
	output wire o_oe_n,
	output wire o_we_n,
	output wire [3:0] o_byte_lane_select_n,
	output wire [3:0] o_cs_n
);

	localparam [6:0] S_IDLE = 7'h01;
	localparam [6:0] S_TURN = 7'h02;
	localparam [6:0] S_RD = 7'h04;
	localparam [6:0] S_WSET = 7'h08;
	localparam [6:0] S_WSTB = 7'h10;
	localparam [6:0] S_WHOLD = 7'h20;
	localparam [6:0] S_FIN = 7'h40;

	reg [6:0] state_reg;
	reg dp_mem_reg;
	reg dp_cfg_reg;
	reg dp_write_reg;
	reg [2:0] dp_size_reg;
	reg [31:0] dp_addr_reg;
	reg [31:0] rdata_reg;
	reg [31:0] wdata_reg;
	reg [31:0] cur_addr_reg;
	reg [31:0] odata_reg;
	reg [3:0] lane_mask_reg;
	reg [1:0] beats_reg;
	reg [5:0] cnt_reg;
	reg last_valid_reg;
	reg last_rd_reg;
	reg [1:0] last_bank_reg;
	reg [31:0] last_next_reg;

	wire [31:0] cfg_val [0:3];
	wire [3:0] wr_cfg;
	wire [3:0] set_oversize;
	wire [3:0] set_protect;

	// ============================================================
	// Address phase decode
	wire take = i_hsel & i_htrans[1] & i_hready;
	wire hit_cfg = i_haddr[31:4] == `SMC_CFG_BASE_HI;
	wire hit_mem = i_haddr[31:26] == `SMC_MEM_BASE_HI;

	// Current bank fields
	wire [1:0] bank = dp_addr_reg[25:24];
	wire [31:0] cur_cfg = cfg_val[bank];
	wire [3:0] f_idle = cur_cfg[`SMC_F_IDLE];
	wire [4:0] f_rwait = cur_cfg[`SMC_F_RWAIT];
	wire [4:0] f_wwait = cur_cfg[`SMC_F_WWAIT];
	wire f_lane = cur_cfg[`SMC_B_LANE];
	wire f_wprot = cur_cfg[`SMC_B_WPROT];
	wire f_burst = cur_cfg[`SMC_B_BURST];
	wire [1:0] f_width = cur_cfg[`SMC_F_WIDTH];
	wire oversize = dp_size_reg > `SMC_SIZE_WORD;

	// Width code as log2 of bytes; reserved code treated as 32 bits
	wire [1:0] wlog = (f_width == `SMC_W8) ? 2'd0 :
		(f_width == `SMC_W16) ? 2'd1 : 2'd2;
	wire [2:0] wbytes = 3'd1 << wlog;
	wire [1:0] slog = dp_size_reg[1:0];
	wire [1:0] beats_m1 = (slog > wlog) ?
		((slog - wlog == 2'd2) ? 2'd3 : 2'd1) : 2'd0;

	wire st_idle = state_reg == S_IDLE;
	wire st_turn = state_reg == S_TURN;
	wire [31:0] nxt_addr = cur_addr_reg + {29'h0, wbytes};
	wire [31:0] beat_addr = st_idle ? dp_addr_reg :
		(st_turn ? cur_addr_reg : nxt_addr);
	wire [31:0] wsrc = st_idle ? i_hwdata : wdata_reg;

	// Bus turnaround needed on bank change or direction change
	wire need_turn = last_valid_reg & ((bank != last_bank_reg) |
		(last_rd_reg == dp_write_reg));

	// Subsequent burst read: contiguous, same bank, not quad-aligned
	wire [1:0] quad_idx = (wlog == 2'd0) ? beat_addr[1:0] :
		(wlog == 2'd1) ? beat_addr[2:1] : beat_addr[3:2];
	wire burst_next = f_burst & ~dp_write_reg & last_valid_reg &
		last_rd_reg & (last_bank_reg == bank) &
		(beat_addr == last_next_reg) & (quad_idx != 2'd0);

	// ============================================================
	// Write lane mask and lane steering for one beat
	reg [3:0] lane_mask;
	reg [31:0] lane_data;
	always @*
	begin
		lane_mask = 4'h1;
		lane_data = wsrc;
		case (wlog)
			2'd2:
			begin
				if (slog == 2'd0)
					lane_mask = 4'h1 << beat_addr[1:0];
				else if (slog == 2'd1)
					lane_mask = beat_addr[1] ? 4'hc : 4'h3;
				else
					lane_mask = 4'hf;
			end
			2'd1:
			begin
				lane_mask = (slog == 2'd0) ?
					(beat_addr[0] ? 4'h2 : 4'h1) : 4'h3;
				lane_data = {2{wsrc[{beat_addr[1], 4'h0} +: 16]}};
			end
			default:
				lane_data = {4{wsrc[{beat_addr[1:0], 3'h0} +: 8]}};
		endcase
	end

	// ============================================================
	// Bank setup registers
	genvar k;
	generate
		for (k = 0; k < 4; k = k + 1)
		begin : g_bank
			assign wr_cfg[k] = dp_cfg_reg & dp_write_reg & ~oversize &
				(dp_addr_reg[3:2] == k);
			assign set_oversize[k] = oversize & ((dp_cfg_reg &
				(dp_addr_reg[3:2] == k)) | (st_idle & dp_mem_reg &
				(bank == k)));
			assign set_protect[k] = st_idle & dp_mem_reg & dp_write_reg &
				~oversize & f_wprot & (bank == k);
			bank_setup_register #(
				.RESET_VALUE((k == 0) ? `SMC_RST_BANK0 :
					(k == 1) ? `SMC_RST_BANK1 :
					(k == 2) ? `SMC_RST_BANK2 : `SMC_RST_BANK3)
			) u_bank (
				.i_clk_sys(i_clk_sys),
				.i_rst_b(i_rst_b),
				.i_wr(wr_cfg[k]),
				.i_wdata(i_hwdata),
				.i_set_oversize(set_oversize[k]),
				.i_set_protect(set_protect[k]),
				.o_value(cfg_val[k])
			);
		end
	endgenerate

	// ============================================================
	// Beat start: read length or write setup
	task start_beat;
	begin
		cur_addr_reg <= beat_addr;
		lane_mask_reg <= lane_mask;
		odata_reg <= lane_data;
		if (dp_write_reg)
			state_reg <= S_WSET;
		else
		begin
			state_reg <= S_RD;
			if (burst_next)
				cnt_reg <= {1'b0, f_wwait};
			else
				cnt_reg <= {1'b0, f_rwait} + 6'd2;
		end
	end
	endtask

	// Beat end: record history, then next beat or finish
	task end_beat;
	begin
		last_valid_reg <= 1'b1;
		last_rd_reg <= ~dp_write_reg;
		last_bank_reg <= bank;
		last_next_reg <= nxt_addr;
		if (beats_reg != 2'd0)
		begin
			beats_reg <= beats_reg - 2'd1;
			start_beat;
		end
		else
			state_reg <= S_FIN;
	end
	endtask

	// ============================================================
	// Bus slave capture and external cycle sequencer
	always @(posedge i_clk_sys or negedge i_rst_b)
	if (!i_rst_b)
	begin
		state_reg <= S_IDLE;
		dp_mem_reg <= 1'b0;
		dp_cfg_reg <= 1'b0;
		dp_write_reg <= 1'b0;
		dp_size_reg <= 3'h0;
		dp_addr_reg <= 32'h0000_0000;
		rdata_reg <= 32'h0000_0000;
		wdata_reg <= 32'h0000_0000;
		cur_addr_reg <= 32'h0000_0000;
		odata_reg <= 32'h0000_0000;
		lane_mask_reg <= 4'h0;
		beats_reg <= 2'd0;
		cnt_reg <= 6'd0;
		last_valid_reg <= 1'b0;
		last_rd_reg <= 1'b0;
		last_bank_reg <= 2'd0;
		last_next_reg <= 32'h0000_0000;
	end
	else
	begin
		if (i_hready && (st_idle ? !dp_mem_reg : state_reg == S_FIN))
		begin
			dp_mem_reg <= take & hit_mem;
			dp_cfg_reg <= take & hit_cfg;
			dp_write_reg <= i_hwrite;
			dp_size_reg <= i_hsize;
			dp_addr_reg <= i_haddr;
			rdata_reg <= (take & hit_cfg) ? cfg_val[i_haddr[3:2]] :
				32'h0000_0000;
		end
		else
			dp_cfg_reg <= 1'b0;
		case (state_reg)
			S_IDLE:
			if (dp_mem_reg)
			begin
				wdata_reg <= i_hwdata;
				beats_reg <= beats_m1;
				if (oversize | (dp_write_reg & f_wprot))
					state_reg <= S_FIN;
				else if (need_turn)
				begin
					cur_addr_reg <= dp_addr_reg;
					cnt_reg <= {2'b00, f_idle};
					state_reg <= S_TURN;
				end
				else
					start_beat;
			end
			S_TURN:
			if (cnt_reg == 6'd0)
				start_beat;
			else
				cnt_reg <= cnt_reg - 6'd1;
			S_RD:
			if (cnt_reg == 6'd0)
			begin
				if (wlog == 2'd2)
					rdata_reg <= i_data;
				else if (wlog == 2'd1)
					rdata_reg[{cur_addr_reg[1], 4'h0} +: 16] <= i_data[15:0];
				else
					rdata_reg[{cur_addr_reg[1:0], 3'h0} +: 8] <= i_data[7:0];
				end_beat;
			end
			else
				cnt_reg <= cnt_reg - 6'd1;
			S_WSET:
			begin
				cnt_reg <= {1'b0, f_wwait};
				state_reg <= S_WSTB;
			end
			S_WSTB:
			if (cnt_reg == 6'd0)
				state_reg <= S_WHOLD;
			else
				cnt_reg <= cnt_reg - 6'd1;
			S_WHOLD:
				end_beat;
			S_FIN:
				state_reg <= S_IDLE;
			default:
				state_reg <= S_IDLE;
		endcase
	end

	// ============================================================
	// Bus answers
	assign o_hreadyout = st_idle ? !dp_mem_reg : (state_reg == S_FIN);
	assign o_hresp = `SMC_HRESP_OKAY;
	assign o_hrdata = rdata_reg;

	// External pins, all strobes active low
	wire rd_act = state_reg == S_RD;
	wire wr_act = (state_reg == S_WSTB) | (state_reg == S_WHOLD);
	assign o_addr = cur_addr_reg[23:0];
	assign o_data = odata_reg;
	assign o_data_oe = (state_reg == S_WSET) | wr_act;
	assign o_oe_n = ~rd_act;
	assign o_we_n = ~(state_reg == S_WSTB);
	assign o_cs_n = (rd_act | wr_act) ? ~(4'h1 << bank) : 4'hf;
	assign o_byte_lane_select_n = rd_act ? {4{~f_lane}} :
		((state_reg == S_WSTB) ? ~lane_mask_reg : 4'hf);

endmodule
`default_nettype wire

// File: core/smc_regs.vh
// Register map, field layout, reset values and codes of the static memory controller
//
// Function
// - Idle cycles on direction or bank change
// - Read lasts read wait plus three
// - Read-lane bit sets all byte lanes
// - Write: setup, strobe wait plus one, hold
// - Burst subsequent read lasts write wait plus one
// - Oversize bus request sets error flag
// - Protected write sets flag, one clears
// - Protect bit blocks writes to bank
// - Burst bit enables short subsequent reads
// - Width field selects 8/16/32 bits
// - Reserved bits written zero, read undefined
// - Width reset: 32, 32, 16, 8 bits
// - Active-low strobes, 24-bit address bus
// - Bank decoded from address bits 25:24
// - Writes assert only addressed byte lanes
// - Burst of four, three fast reads where each read transfer is a single beat
`ifndef SMC_REGS_VH
`define SMC_REGS_VH

// ============================================================
// Address decode
`define SMC_CFG_BASE_HI 28'hffe0_000
`define SMC_MEM_BASE_HI 6'h20
`define SMC_OFF_BANK0 32'hffe0_0000
`define SMC_OFF_BANK1 32'hffe0_0004
`define SMC_OFF_BANK2 32'hffe0_0008
`define SMC_OFF_BANK3 32'hffe0_000c

// ============================================================
// Bank setup register fields
`define SMC_F_IDLE 3:0
`define SMC_F_RWAIT 9:5
`define SMC_B_LANE 10
`define SMC_F_WWAIT 15:11
`define SMC_B_OVERSIZE 24
`define SMC_B_PROTECT_FLAG 25
`define SMC_B_WPROT 26
`define SMC_B_BURST 27
`define SMC_F_WIDTH 29:28
`define SMC_F_ACCESS_TYPE 31:30
`define SMC_WR_MASK 32'h3c00_ffef

// ============================================================
// Reset values
`define SMC_RST_BANK0 32'h2000_fbef
`define SMC_RST_BANK1 32'h2000_fbef
`define SMC_RST_BANK2 32'h1000_fbef
`define SMC_RST_BANK3 32'h0000_fbef

// ============================================================
// Width codes and bus sizes
`define SMC_W8 2'h0
`define SMC_W16 2'h1
`define SMC_W32 2'h2
`define SMC_SIZE_WORD 3'h2
`define SMC_HRESP_OKAY 2'h0

`endif

// File: core/bank_setup_register.v
// One bank setup register with its two sticky error flags
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.vh"

module bank_setup_register #(
	parameter [31:0] RESET_VALUE = `SMC_RST_BANK3
) (
	input wire i_clk_sys,
	input wire i_rst_b,
	input wire i_wr,
	input wire [31:0] i_wdata,
	input wire i_set_oversize,
	input wire i_set_protect,
	output wire [31:0] o_value
);

	reg [31:0] cfg_reg;
	reg oversize_reg;
	reg protect_reg;

	// ============================================================
	// Storage: writable fields only, flags set-wins-over-clear
	always @(posedge i_clk_sys or negedge i_rst_b)
	if (!i_rst_b)
	begin
		cfg_reg <= RESET_VALUE & `SMC_WR_MASK;
		oversize_reg <= 1'b0;
		protect_reg <= 1'b0;
	end
	else
	begin
		if (i_wr)
			cfg_reg <= i_wdata & `SMC_WR_MASK;
		oversize_reg <= i_set_oversize | (oversize_reg &
			~(i_wr & i_wdata[`SMC_B_OVERSIZE]));
		protect_reg <= i_set_protect | (protect_reg &
			~(i_wr & i_wdata[`SMC_B_PROTECT_FLAG]));
	end

	// Reserved and access-type bits read as zero
	assign o_value = cfg_reg | {6'h00, protect_reg, oversize_reg, 24'h00_0000};

endmodule
`default_nettype wire

// File: verif/smc_props.sv
// Checker of external cycle shapes at the controller ports
`timescale 1ns/1ps
`default_nettype none
module smc_props (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic o_hreadyout,
	input wire logic [1:0] o_hresp,
	input wire logic [23:0] o_addr,
	input wire logic o_data_oe,
	input wire logic o_oe_n,
	input wire logic o_we_n,
	input wire logic [3:0] o_byte_lane_select_n,
	input wire logic [3:0] o_cs_n
);
// ========
// Length of the current read beat; a new address starts a new beat
logic [5:0] oe_run_reg;
logic [23:0] addr_prev_reg;
always @(posedge i_clk_sys or negedge i_rst_b)
begin
	if (!i_rst_b)
	begin
		oe_run_reg <= 6'h00;
		addr_prev_reg <= 24'h00_0000;
	end
	else
	begin
		addr_prev_reg <= o_addr;
		if (o_oe_n)
			oe_run_reg <= 6'h00;
		else if (o_addr != addr_prev_reg)
			oe_run_reg <= 6'h01;
		else
			oe_run_reg <= oe_run_reg + 6'h01;
	end
end
default clocking @(posedge i_clk_sys); endclocking
default disable iff (!i_rst_b);
// Edges of the write strobe
sequence s_we_fall;
	o_we_n ##1 !o_we_n;
endsequence
sequence s_we_rise;
	!o_we_n ##1 o_we_n;
endsequence
// ========
// Properties
AST_ONE_BANK: assert property ($onehot0(~o_cs_n))
	else $error("two chip selects low");
AST_OE_WE: assert property (o_oe_n || o_we_n)
	else $error("read and write strobes together");
AST_READ_LANES: assert property (!o_oe_n |->
	o_byte_lane_select_n inside {4'h0, 4'hf}) else $error("read lanes mixed");
AST_READ_LEN: assert property (oe_run_reg <= 6'h22)
	else $error("read strobe too long");
AST_SETUP: assert property (s_we_fall |-> $past(o_cs_n) == 4'hf &&
	$past(o_data_oe) && o_cs_n != 4'hf) else $error("no setup cycle");
AST_HOLD: assert property (s_we_rise |-> o_cs_n != 4'hf &&
	o_byte_lane_select_n == 4'hf && o_data_oe) else $error("bad hold cycle");
AST_WR_LANES: assert property (!o_we_n |-> o_cs_n != 4'hf &&
	o_byte_lane_select_n != 4'hf) else $error("write without lanes");
AST_OKAY: assert property (o_hresp == 2'h0)
	else $error("response not okay");
AST_MEM_STALL: assert property (i_hsel && i_htrans[1] && o_hreadyout &&
	i_haddr[31:26] == 6'h20 |=> !o_hreadyout) else $error("no stall");
endmodule
bind static_memory_bank_controller smc_props u_props (
	.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_hsel(i_hsel),
	.i_haddr(i_haddr), .i_htrans(i_htrans), .o_hreadyout(o_hreadyout),
	.o_hresp(o_hresp), .o_addr(o_addr), .o_data_oe(o_data_oe), .o_oe_n(o_oe_n),
	.o_we_n(o_we_n), .o_byte_lane_select_n(o_byte_lane_select_n),
	.o_cs_n(o_cs_n));
`default_nettype wire

// File: verif/ext_sram_model.sv
// Behavioural asynchronous SRAM on the external bus
`timescale 1ns/1ps
`default_nettype none
module ext_sram_model (
	input wire logic i_clk_sys,
	input wire logic [23:0] i_addr,
	input wire logic [31:0] i_data,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic [3:0] i_byte_lane_select_n,
	input wire logic [3:0] i_cs_n,
	output logic [31:0] o_data
);
logic [7:0] mem [4][64];
logic [31:0] last = 32'h0000_0000;
// Word index per part width: banks 0 and 1 hold 32-bit parts,
// bank 2 a 16-bit part and bank 3 an 8-bit part
wire [5:0] a = !i_cs_n[2] ? i_addr[6:1] :
	(!i_cs_n[3] ? i_addr[5:0] : i_addr[7:2]);
wire rd = (i_cs_n != 4'hf) && !i_oe_n;
// Drive stored bytes while read, inverse of last value otherwise
always_comb
	o_data = rd ? {mem[3][a], mem[2][a], mem[1][a], mem[0][a]} : ~last;
// Store the bytes whose lanes are low during the strobe
always @(posedge i_clk_sys)
begin
	if (rd)
		last <= o_data;
	if ((i_cs_n != 4'hf) && !i_we_n)
		for (int k = 0; k < 4; k++)
			if (!i_byte_lane_select_n[k])
				mem[k][a] <= i_data[8 * k +: 8];
end
endmodule
`default_nettype wire

// File: verif/tb_static_memory_bank_controller.sv
// Bench: bus transfers against a behavioural SRAM
`timescale 1ns/1ps
`default_nettype none
module tb_static_memory_bank_controller;
logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
logic [1:0] htrans = 2'h0;
logic [2:0] hsize = 3'h2;
logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rdata;
logic [31:0] rst_v [4] = '{32'h2000_fbef, 32'h2000_fbef, 32'h1000_fbef,
	32'h0000_fbef};
logic [3:0] rd_lanes, wr_lanes;
int err_count = 0, num_checks = 0, we_cyc, oe_cyc;
wire [31:0] hrdata, d_out, d_in;
wire [23:0] a24;
wire [3:0] lanes, cs_n;
wire hrdy, doe, oe_n, we_n;
localparam logic [31:0] B1 = 32'hffe0_0004, M1 = 32'h8100_0010;
static_memory_bank_controller dut (
	.i_clk_sys(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr),
	.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
	.i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
	.o_hreadyout(hrdy), .o_hresp(), .o_addr(a24), .i_data(d_in),
	.o_data(d_out), .o_data_oe(doe), .o_oe_n(oe_n), .o_we_n(we_n),
	.o_byte_lane_select_n(lanes), .o_cs_n(cs_n));
ext_sram_model mem_u (
	.i_clk_sys(clk), .i_addr(a24), .i_data(d_out), .i_oe_n(oe_n),
	.i_we_n(we_n), .i_byte_lane_select_n(lanes), .i_cs_n(cs_n),
	.o_data(d_in));
// ========
// Clock and strobe monitor
always #5 clk = ~clk;
always @(posedge clk)
begin
	we_cyc += !we_n;
	oe_cyc += !oe_n;
	if (!oe_n) rd_lanes = lanes;
	if (!we_n) wr_lanes = lanes;
end
// ========
// Tasks
task check(input logic [31:0] seen, input logic [31:0] exp);
	num_checks++;
	if (seen !== exp)
	begin
		err_count++;
		$display("wrong value at %0t: got %h want %h", $time, seen, exp);
	end
endtask
task xfer(input logic [31:0] a, input logic w, input logic [2:0] sz,
	input logic [31:0] d);
	int n;
	n = 0;
	@(negedge clk);
	hsel = 1'b1; htrans = 2'h2; haddr = a; hwrite = w; hsize = sz;
	we_cyc = 0; oe_cyc = 0;
	@(negedge clk);
	htrans = 2'h0; hwdata = d;
	while (!hrdy && n < 300)
	begin
		@(negedge clk);
		n++;
	end
	// A transfer that never completes counts as a mismatch
	if (!hrdy)
		err_count++;
	rdata = hrdata;
	@(posedge clk);
endtask
task report_and_stop;
	$display("checks %0d errors %0d", num_checks, err_count);
	if (err_count == 0 && num_checks > 0)
		$display("TEST PASSED");
	else
		$display("TEST FAILED");
	$finish;
endtask
// ========
// Tests
initial
begin
	repeat (12) @(negedge clk);
	rst_b = 1'b1;
	for (int i = 0; i < 4; i++)
	begin
		xfer(32'hffe0_0000 + 4 * i, 0, 3'h2, 0);
		check(rdata, rst_v[i]);
	end
	xfer(32'hffe0_0000, 1, 3'h2, 32'h1000_fbef);
	xfer(32'hffe0_0000, 0, 3'h2, 0);
	check(rdata, 32'h1000_fbef);
	xfer(B1, 1, 3'h2, 32'h2000_0400);
	xfer(B1, 0, 3'h2, 0);
	check(rdata, 32'h2000_0400);
	xfer(32'hffe0_0008, 1, 3'h2, 32'h1000_0000);
	xfer(M1, 1, 3'h2, 32'h1234_5678);
	check(we_cyc, 1);
	check(wr_lanes, 4'h0);
	xfer(M1, 0, 3'h2, 0);
	check(rdata, 32'h1234_5678);
	check(oe_cyc, 3);
	check(rd_lanes, 4'h0);
	xfer(M1 + 2, 1, 3'h0, 32'h00ab_0000);
	check(wr_lanes, 4'hb);
	xfer(M1, 0, 3'h2, 0);
	check(rdata, 32'h12ab_5678);
	xfer(32'h8200_0000, 1, 3'h2, 32'hcafe_f00d);
	check(we_cyc, 2);
	xfer(32'h8200_0000, 0, 3'h2, 0);
	check(rdata, 32'hcafe_f00d);
	check(oe_cyc, 6);
	check(rd_lanes, 4'hf);
	xfer(M1, 0, 3'h3, 0);
	check(oe_cyc, 0);
	xfer(B1, 0, 3'h2, 0);
	check(rdata, 32'h2100_0400);
	xfer(B1, 1, 3'h2, 32'h2500_0400);
	xfer(M1, 1, 3'h2, 0);
	check(we_cyc, 0);
	xfer(B1, 0, 3'h2, 0);
	check(rdata, 32'h2600_0400);
	xfer(B1, 1, 3'h2, 32'h2200_0400);
	xfer(B1, 0, 3'h2, 0);
	check(rdata, 32'h2000_0400);
	xfer(M1, 0, 3'h2, 0);
	check(rdata, 32'h12ab_5678);
	xfer(B1, 1, 3'h2, 32'h2800_0c00);
	xfer(M1 + 8, 1, 3'h2, 32'h5555_aaaa);
	check(we_cyc, 2);
	xfer(M1, 0, 3'h2, 0);
	check(oe_cyc, 3);
	xfer(M1 + 4, 0, 3'h2, 0);
	check(oe_cyc, 2);
	xfer(M1 + 8, 0, 3'h2, 0);
	check(oe_cyc, 2);
	check(rdata, 32'h5555_aaaa);
	// Second reset in mid-run brings the bank registers back
	@(negedge clk);
	rst_b = 1'b0;
	repeat (2) @(negedge clk);
	rst_b = 1'b1;
	xfer(B1, 0, 3'h2, 0);
	check(rdata, rst_v[1]);
	report_and_stop;
end
// Watchdog against a hung transfer
initial
begin
	#100000;
	err_count++;
	report_and_stop;
end
endmodule
`default_nettype wire
